// ### hdl/berh_cfg.svh
// register offsets, field positions, reset values and codes of the handler
`ifndef BERH_CFG_SVH
`define BERH_CFG_SVH
`define BERH_OFS_DSP_CODE 6'h00
`define BERH_OFS_DSP_PEND 6'h04
`define BERH_OFS_ABORT_CTL 6'h08
`define BERH_OFS_DATA_FAULT_ADDRESS_REG 6'h0C
`define BERH_OFS_TC_BUS_ERROR_CAPTURE_REG 6'h10
`define BERH_OFS_TC_DETAIL 6'h14
`define BERH_OFS_TC_IEN 6'h18
`define BERH_OFS_RIO_STAT 6'h1C
`define BERH_OFS_RIO_CAPT0 6'h20
`define BERH_OFS_RIO_CAPT1 6'h24
`define BERH_OFS_RIO_ROUTE 6'h28
`define BERH_OFS_TELECOM_SERIAL_PORT_SEL 6'h2C
`define BERH_OFS_TELECOM_SERIAL_PORT_HEAD 6'h30
`define BERH_OFS_TELECOM_SERIAL_PORT_POP 6'h34
`define BERH_OFS_LINK_STAT 6'h38
`define BERH_BIT_MASTER_DMA_PORT_PEND 0
`define BERH_BIT_ECCW_PEND 1
`define BERH_BIT_ASYNC_MASK 0
`define BERH_BIT_TC_VALID 0
`define BERH_BIT_LINK_ERR 0
`define BERH_RST_ASYNC_MASK 1'h1
`define BERH_DSP_ECC_CODE 3'h4
`define BERH_ECC_RESP_STATUS 3'h1
`define BERH_OK_STATUS 3'h0
`endif

// ### hdl/berh_pkg.sv
// types shared by the bus error response handler
package berh_pkg;
   typedef enum logic [3:0] {
      BERH_M_DSP,
      BERH_M_APP,
      BERH_M_PCIE,
      BERH_M_DMA_TC,
      BERH_M_PKT_DMA,
      BERH_M_TELECOM_SERIAL_PORT,
      BERH_M_RIO,
      BERH_M_LINK,
      BERH_M_ETH10G
   } berh_master_t;
endpackage

// ### hdl/berh_err_queue.sv
// per-channel error code queue of the telecom serial port
`timescale 1ns/1ps
module berh_err_queue #(
   parameter int W = 3,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   input wire logic pop,
   output logic [W-1:0] head,
   output logic not_empty,
   output logic full
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];
   logic [W-1:0] mem_next [DEPTH];
   logic [AW-1:0] rd_reg, rd_next, wr_reg, wr_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic do_push, do_pop;

   always_comb
   begin
      do_push = push && (cnt_reg != DEPTH[AW:0]);
      do_pop = pop && (cnt_reg != '0);
      mem_next = mem_reg;
      rd_next = rd_reg;
      wr_next = wr_reg;
      cnt_next = cnt_reg;
      if (do_push)
      begin
         mem_next[wr_reg] = push_data;
         wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (do_pop)
         rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      if (do_push && !do_pop)
         cnt_next = cnt_reg + 1'b1;
      else if (do_pop && !do_push)
         cnt_next = cnt_reg - 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_reg[i] <= '0;
         rd_reg <= '0;
         wr_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         mem_reg <= mem_next;
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         cnt_reg <= cnt_next;
      end
   end

   assign head = mem_reg[rd_reg];
   assign not_empty = (cnt_reg != '0);
   assign full = (cnt_reg == DEPTH[AW:0]);
endmodule

// ### hdl/berh_top.sv
// bus error response handling for all interconnect masters except BERH_M_ETH10G
`timescale 1ns/1ps
`include "berh_cfg.svh"
module berh_top
   import berh_pkg::*;
#(
   parameter int NCH = 4,
   parameter int NCORE = 4,
   parameter int QDEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic mc_valid,
   input wire logic mc_write,
   input wire logic mc_ecc_err,
   input wire berh_master_t mc_master,
   input wire logic [31:0] mc_addr,
   input wire logic mc_sync,
   input wire logic mc_posted,
   input wire logic [3:0] mc_privid,
   input wire logic [7:0] mc_mstid,
   input wire logic [1:0] mc_chan,
   output logic resp_valid,
   output logic resp_write,
   output berh_master_t resp_master,
   output logic [2:0] resp_status,
   output logic master_dma_port_err_int,
   output logic app_ext_abort,
   output logic pcie_cpl_abort,
   output logic dma_err_int,
   output logic dma_xfer_done,
   output logic [NCH-1:0] channel_error_event,
   output logic [NCORE-1:0] rio_core_int,
   input wire logic link_active,
   input wire logic remote_rvalid,
   input wire logic [2:0] remote_rstatus,
   output logic local_rvalid,
   output logic [2:0] local_rstatus,
   output logic chip_link_error_int
);
   logic av_ack_reg, av_ack_next;
   logic [31:0] av_rdata_reg, av_rdata_next;
   logic resp_valid_reg, resp_valid_next, resp_write_reg, resp_write_next;
   berh_master_t resp_master_reg, resp_master_next;
   logic [2:0] resp_status_reg, resp_status_next;
   logic [2:0] dsp_code_reg, dsp_code_next;
   logic master_dma_port_pend_reg, master_dma_port_pend_next, eccw_pend_reg, eccw_pend_next;
   logic abort_mask_reg, abort_mask_next, abort_reg, abort_next;
   logic [31:0] data_fault_address_reg, data_fault_address_reg_next;
   logic cpl_abort_reg, cpl_abort_next;
   logic tc_valid_reg, tc_valid_next, tc_ien_reg, tc_ien_next;
   logic tc_done_reg, tc_done_next;
   logic [2:0] tc_code_reg, tc_code_next;
   logic [31:0] error_detail_reg, tc_detail_next;
   logic [15:0] address_map_int_status_reg, rio_stat_next;
   logic [31:0] address_map_err_capture_0, capt0_next;
   logic [11:0] address_map_err_capture_1, capt1_next;
   logic [31:0] interrupt_condition_routing_reg, route_next;
   logic [NCORE-1:0] rio_int_next;
   logic [1:0] telecom_serial_port_sel_reg, telecom_serial_port_sel_next;
   logic [NCH-1:0] telecom_serial_port_evt_reg, telecom_serial_port_evt_next;
   logic link_rvalid_reg, link_rvalid_next;
   logic [2:0] link_rstatus_reg, link_rstatus_next;
   logic link_err_reg, link_err_next;
   logic err, wr_en;
   logic [NCH-1:0] q_push, q_pop, q_ne, q_full;
   logic [2:0] q_head [NCH];

   assign err = mc_valid && mc_ecc_err && (mc_master != BERH_M_ETH10G);
   assign wr_en = avs_write && av_ack_reg;

   // telecom serial port per-channel error queues
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_q
         assign q_push[g] = err && (mc_master == BERH_M_TELECOM_SERIAL_PORT)
            && (mc_chan == 2'(g));
         assign q_pop[g] = wr_en && (avs_address == `BERH_OFS_TELECOM_SERIAL_PORT_POP)
            && (telecom_serial_port_sel_reg == 2'(g));
         berh_err_queue #(
            .W(3),
            .DEPTH(QDEPTH)
         ) u_q (
            .clk(clk),
            .rst_n(rst_n),
            .push(q_push[g]),
            .push_data(`BERH_ECC_RESP_STATUS),
            .pop(q_pop[g]),
            .head(q_head[g]),
            .not_empty(q_ne[g]),
            .full(q_full[g])
         );
      end
   endgenerate

   // response path and per-master reactions
   always_comb
   begin
      resp_valid_next = mc_valid;
      resp_write_next = mc_write;
      resp_master_next = mc_master;
      resp_status_next = `BERH_OK_STATUS;
      if (err)
         resp_status_next = `BERH_ECC_RESP_STATUS;
      dsp_code_next = dsp_code_reg;
      master_dma_port_pend_next = master_dma_port_pend_reg;
      eccw_pend_next = eccw_pend_reg;
      if (wr_en && avs_address == `BERH_OFS_DSP_PEND)
      begin
         master_dma_port_pend_next = master_dma_port_pend_reg
            && !avs_writedata[`BERH_BIT_MASTER_DMA_PORT_PEND];
         eccw_pend_next = eccw_pend_reg
            && !avs_writedata[`BERH_BIT_ECCW_PEND];
      end
      if (err && mc_master == BERH_M_DSP && !master_dma_port_pend_reg && !eccw_pend_reg)
      begin
         dsp_code_next = `BERH_DSP_ECC_CODE;
         master_dma_port_pend_next = 1'b1;
      end
      if (err && mc_write && !eccw_pend_reg && !master_dma_port_pend_reg)
         eccw_pend_next = 1'b1;
      abort_mask_next = abort_mask_reg;
      if (wr_en && avs_address == `BERH_OFS_ABORT_CTL)
         abort_mask_next = avs_writedata[`BERH_BIT_ASYNC_MASK];
      abort_next = err && mc_master == BERH_M_APP && !abort_mask_reg;
      data_fault_address_reg_next = data_fault_address_reg;
      if (err && mc_master == BERH_M_APP && mc_sync)
         data_fault_address_reg_next = mc_addr;
      // no log or interrupt kept for PCIe except eccw_pend_reg, set by a write error while neither pending flag is set
      cpl_abort_next = err && mc_master == BERH_M_PCIE && !mc_write;
      tc_valid_next = tc_valid_reg;
      tc_code_next = tc_code_reg;
      tc_detail_next = error_detail_reg;
      tc_ien_next = tc_ien_reg;
      if (wr_en && avs_address == `BERH_OFS_TC_BUS_ERROR_CAPTURE_REG)
         tc_valid_next = tc_valid_reg && !avs_writedata[`BERH_BIT_TC_VALID];
      if (wr_en && avs_address == `BERH_OFS_TC_IEN)
         tc_ien_next = avs_writedata[0];
      if (err && mc_master == BERH_M_DMA_TC)
      begin
         tc_valid_next = 1'b1;
         tc_code_next = `BERH_ECC_RESP_STATUS;
         tc_detail_next = mc_addr;
      end
      tc_done_next = mc_valid && mc_master == BERH_M_DMA_TC;
      // packet DMA errors touch no state except eccw_pend_reg, which a write error sets while neither pending flag is set
      rio_stat_next = address_map_int_status_reg;
      capt0_next = address_map_err_capture_0;
      capt1_next = address_map_err_capture_1;
      route_next = interrupt_condition_routing_reg;
      if (wr_en && avs_address == `BERH_OFS_RIO_STAT)
         rio_stat_next = address_map_int_status_reg & ~avs_writedata[15:0];
      if (wr_en && avs_address == `BERH_OFS_RIO_ROUTE)
         route_next = avs_writedata;
      if (err && mc_master == BERH_M_RIO)
      begin
         rio_stat_next[mc_privid] = 1'b1;
         if (!mc_posted)
         begin
            capt0_next = mc_addr;
            capt1_next = {mc_privid, mc_mstid};
         end
      end
      telecom_serial_port_sel_next = telecom_serial_port_sel_reg;
      if (wr_en && avs_address == `BERH_OFS_TELECOM_SERIAL_PORT_SEL)
         telecom_serial_port_sel_next = avs_writedata[1:0];
      telecom_serial_port_evt_next = q_push & ~q_full;
      link_rvalid_next = link_active && remote_rvalid;
      link_rstatus_next = link_active ? remote_rstatus : `BERH_OK_STATUS;
      link_err_next = link_err_reg;
      if (wr_en && avs_address == `BERH_OFS_LINK_STAT)
         link_err_next = link_err_reg && !avs_writedata[`BERH_BIT_LINK_ERR];
      if ((link_active && remote_rvalid
         && remote_rstatus != `BERH_OK_STATUS)
         || (err && mc_master == BERH_M_LINK))
         link_err_next = 1'b1;
   end

   always_comb
   begin
      rio_int_next = '0;
      for (int b = 0; b < 16; b++)
         for (int c = 0; c < NCORE; c++)
            if (address_map_int_status_reg[b]
               && interrupt_condition_routing_reg[2*b +: 2] == 2'(c))
               rio_int_next[c] = 1'b1;
   end

   // register bus slave with one wait cycle
   always_comb
   begin
      av_ack_next = (avs_read || avs_write) && !av_ack_reg;
      av_rdata_next = av_rdata_reg;
      if (avs_read && !av_ack_reg)
      begin
         case (avs_address)
            `BERH_OFS_DSP_CODE: av_rdata_next = {29'h0, dsp_code_reg};
            `BERH_OFS_DSP_PEND:
               av_rdata_next = {30'h0, eccw_pend_reg, master_dma_port_pend_reg};
            `BERH_OFS_ABORT_CTL: av_rdata_next = {31'h0, abort_mask_reg};
            `BERH_OFS_DATA_FAULT_ADDRESS_REG: av_rdata_next = data_fault_address_reg;
            `BERH_OFS_TC_BUS_ERROR_CAPTURE_REG:
               av_rdata_next = {28'h0, tc_code_reg, tc_valid_reg};
            `BERH_OFS_TC_DETAIL: av_rdata_next = error_detail_reg;
            `BERH_OFS_TC_IEN: av_rdata_next = {31'h0, tc_ien_reg};
            `BERH_OFS_RIO_STAT:
               av_rdata_next = {16'h0, address_map_int_status_reg};
            `BERH_OFS_RIO_CAPT0: av_rdata_next = address_map_err_capture_0;
            `BERH_OFS_RIO_CAPT1:
               av_rdata_next = {20'h0, address_map_err_capture_1};
            `BERH_OFS_RIO_ROUTE:
               av_rdata_next = interrupt_condition_routing_reg;
            `BERH_OFS_TELECOM_SERIAL_PORT_SEL: av_rdata_next = {30'h0, telecom_serial_port_sel_reg};
            `BERH_OFS_TELECOM_SERIAL_PORT_HEAD:
               av_rdata_next = {28'h0, q_ne[telecom_serial_port_sel_reg],
                  q_head[telecom_serial_port_sel_reg]};
            `BERH_OFS_LINK_STAT: av_rdata_next = {31'h0, link_err_reg};
            default: av_rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         av_ack_reg <= 1'b0;
         av_rdata_reg <= 32'h0;
         resp_valid_reg <= 1'b0;
         resp_write_reg <= 1'b0;
         resp_master_reg <= BERH_M_DSP;
         resp_status_reg <= `BERH_OK_STATUS;
         dsp_code_reg <= 3'h0;
         master_dma_port_pend_reg <= 1'b0;
         eccw_pend_reg <= 1'b0;
         abort_mask_reg <= `BERH_RST_ASYNC_MASK;
         abort_reg <= 1'b0;
         data_fault_address_reg <= 32'h0;
         cpl_abort_reg <= 1'b0;
         tc_valid_reg <= 1'b0;
         tc_code_reg <= 3'h0;
         error_detail_reg <= 32'h0;
         tc_ien_reg <= 1'b0;
         tc_done_reg <= 1'b0;
         address_map_int_status_reg <= 16'h0;
         address_map_err_capture_0 <= 32'h0;
         address_map_err_capture_1 <= 12'h0;
         interrupt_condition_routing_reg <= 32'h0;
         rio_core_int <= '0;
         telecom_serial_port_sel_reg <= 2'h0;
         telecom_serial_port_evt_reg <= '0;
         link_rvalid_reg <= 1'b0;
         link_rstatus_reg <= `BERH_OK_STATUS;
         link_err_reg <= 1'b0;
      end
      else
      begin
         av_ack_reg <= av_ack_next;
         av_rdata_reg <= av_rdata_next;
         resp_valid_reg <= resp_valid_next;
         resp_write_reg <= resp_write_next;
         resp_master_reg <= resp_master_next;
         resp_status_reg <= resp_status_next;
         dsp_code_reg <= dsp_code_next;
         master_dma_port_pend_reg <= master_dma_port_pend_next;
         eccw_pend_reg <= eccw_pend_next;
         abort_mask_reg <= abort_mask_next;
         abort_reg <= abort_next;
         data_fault_address_reg <= data_fault_address_reg_next;
         cpl_abort_reg <= cpl_abort_next;
         tc_valid_reg <= tc_valid_next;
         tc_code_reg <= tc_code_next;
         error_detail_reg <= tc_detail_next;
         tc_ien_reg <= tc_ien_next;
         tc_done_reg <= tc_done_next;
         address_map_int_status_reg <= rio_stat_next;
         address_map_err_capture_0 <= capt0_next;
         address_map_err_capture_1 <= capt1_next;
         interrupt_condition_routing_reg <= route_next;
         rio_core_int <= rio_int_next;
         telecom_serial_port_sel_reg <= telecom_serial_port_sel_next;
         telecom_serial_port_evt_reg <= telecom_serial_port_evt_next;
         link_rvalid_reg <= link_rvalid_next;
         link_rstatus_reg <= link_rstatus_next;
         link_err_reg <= link_err_next;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !av_ack_reg;
   assign avs_readdata = av_rdata_reg;
   assign resp_valid = resp_valid_reg;
   assign resp_write = resp_write_reg;
   assign resp_master = resp_master_reg;
   assign resp_status = resp_status_reg;
   assign master_dma_port_err_int = master_dma_port_pend_reg;
   assign app_ext_abort = abort_reg;
   assign pcie_cpl_abort = cpl_abort_reg;
   assign dma_err_int = tc_valid_reg && tc_ien_reg;
   assign dma_xfer_done = tc_done_reg;
   assign channel_error_event = telecom_serial_port_evt_reg;
   assign local_rvalid = link_rvalid_reg;
   assign local_rstatus = link_rstatus_reg;
   assign chip_link_error_int = link_err_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_RESP_STATUS: assert property (err |=> resp_valid
      && resp_status == `BERH_ECC_RESP_STATUS) else $error("status not set");
   AST_DSP_CODE: assert property (err && mc_master == BERH_M_DSP
      && !master_dma_port_pend_reg && !eccw_pend_reg |=> dsp_code_reg == 3'h4
      && master_dma_port_err_int) else $error("dsp code or int wrong");
   AST_DSP_HOLD: assert property (master_dma_port_pend_reg && !wr_en
      |=> $stable(dsp_code_reg) && master_dma_port_pend_reg) else $error("dsp retrig");
   AST_MASK: assert property (abort_mask_reg |=> !app_ext_abort)
      else $error("abort while masked");
   AST_DATA_FAULT_ADDRESS_REG: assert property (err && mc_master == BERH_M_APP
      && mc_sync |=> data_fault_address_reg == $past(mc_addr))
      else $error("fault address not kept");
   AST_PCIE: assert property (err && mc_master == BERH_M_PCIE
      |=> pcie_cpl_abort == !$past(mc_write)) else $error("bad cpl abort");
   AST_TC_LOG: assert property (err && mc_master == BERH_M_DMA_TC
      |=> tc_valid_reg && error_detail_reg == $past(mc_addr) && dma_xfer_done)
      else $error("tc not logged");
   AST_TC_IEN: assert property (err && mc_master == BERH_M_DMA_TC
      |=> dma_err_int == tc_ien_reg) else $error("tc int not gated");
   AST_PKT: assert property (mc_valid && mc_master == BERH_M_PKT_DMA
      |=> !dma_err_int || $past(dma_err_int)) else $error("pkt dma int");
   AST_TELECOM_SERIAL_PORT: assert property (q_push[0] && !q_full[0]
      |=> channel_error_event[0] ##1 (!channel_error_event[0]
      || $past(q_push[0] && !q_full[0]))) else $error("telecom_serial_port event missing");
   AST_RIO: assert property (err && mc_master == BERH_M_RIO
      && !mc_posted |=> address_map_int_status_reg[$past(mc_privid)]
      && address_map_err_capture_0 == $past(mc_addr))
      else $error("rio capture wrong");
   AST_LINK: assert property (link_active && remote_rvalid
      |=> local_rvalid && local_rstatus == $past(remote_rstatus))
      else $error("link status changed");
   AST_LINK_INT: assert property (link_active && remote_rvalid
      && remote_rstatus != 3'h0 |=> chip_link_error_int)
      else $error("link int missing");

   COV_DSP: cover property (err && mc_master == BERH_M_DSP ##1
      master_dma_port_err_int);
   COV_PCIE_RD: cover property (pcie_cpl_abort);
   COV_RIO_ROUTE: cover property (|rio_core_int);
   COV_TELECOM_SERIAL_PORT: cover property (channel_error_event != '0);
endmodule

// ### bench/berh_mc_model.sv
// memory controller model answering each access with its ecc status
`timescale 1ns/1ps
module berh_mc_model
   import berh_pkg::*;
(
   input wire logic clk,
   output logic mc_valid,
   output logic mc_write,
   output logic mc_ecc_err,
   output berh_master_t mc_master,
   output logic [31:0] mc_addr,
   output logic mc_sync,
   output logic mc_posted,
   output logic [3:0] mc_privid,
   output logic [7:0] mc_mstid,
   output logic [1:0] mc_chan
);
   initial
   begin
      mc_valid = 1'b0;
      mc_write = 1'b0;
      mc_ecc_err = 1'b0;
      mc_master = BERH_M_ETH10G;
      mc_addr = 32'h0;
      mc_sync = 1'b0;
      mc_posted = 1'b0;
      mc_privid = 4'h0;
      mc_mstid = 8'h0;
      mc_chan = 2'h0;
   end
   // one response pulse; write, address, privid and channel scrambled once released
   task automatic answer(input berh_master_t m, input logic w, input logic e,
      input logic [31:0] a, input logic [3:0] p, input logic [1:0] c,
      input logic s, input logic po);
      @(posedge clk);
      mc_valid <= 1'b1;
      mc_write <= w;
      mc_ecc_err <= e;
      mc_master <= m;
      mc_addr <= a;
      mc_privid <= p;
      mc_mstid <= {4'hA, p};
      mc_chan <= c;
      mc_sync <= s;
      mc_posted <= po;
      @(posedge clk);
      mc_valid <= 1'b0;
      mc_write <= ~w;
      mc_addr <= ~a;
      mc_privid <= ~p;
      mc_chan <= ~c;
   endtask
endmodule

// ### bench/berh_top_tb.sv
// self-checking bench of the bus error response handler
`timescale 1ns/1ps
`include "berh_cfg.svh"
module berh_top_tb
   import berh_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0] avs_address = 6'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic avs_waitrequest, mc_valid, mc_write, mc_ecc_err, mc_sync, mc_posted;
   berh_master_t mc_master, resp_master;
   logic [31:0] mc_addr;
   logic [3:0] mc_privid, channel_error_event, rio_core_int;
   logic [7:0] mc_mstid;
   logic [1:0] mc_chan;
   logic resp_valid, resp_write, master_dma_port_err_int, app_ext_abort;
   logic pcie_cpl_abort, dma_err_int, dma_xfer_done, local_rvalid;
   logic [2:0] resp_status, local_rstatus, remote_rstatus = 3'h0;
   logic link_active = 1'b0, remote_rvalid = 1'b0, chip_link_error_int;
   int errors = 0, n_compared = 0;
   always #25 clk = ~clk;
   berh_mc_model mc_u (.clk(clk), .mc_valid(mc_valid), .mc_write(mc_write),
      .mc_ecc_err(mc_ecc_err), .mc_master(mc_master), .mc_addr(mc_addr),
      .mc_sync(mc_sync), .mc_posted(mc_posted), .mc_privid(mc_privid),
      .mc_mstid(mc_mstid), .mc_chan(mc_chan));
   berh_top dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .mc_valid(mc_valid), .mc_write(mc_write), .mc_ecc_err(mc_ecc_err),
      .mc_master(mc_master), .mc_addr(mc_addr), .mc_sync(mc_sync),
      .mc_posted(mc_posted), .mc_privid(mc_privid), .mc_mstid(mc_mstid),
      .mc_chan(mc_chan), .resp_valid(resp_valid), .resp_write(resp_write),
      .resp_master(resp_master), .resp_status(resp_status),
      .master_dma_port_err_int(master_dma_port_err_int),
      .app_ext_abort(app_ext_abort), .pcie_cpl_abort(pcie_cpl_abort),
      .dma_err_int(dma_err_int), .dma_xfer_done(dma_xfer_done),
      .channel_error_event(channel_error_event), .rio_core_int(rio_core_int),
      .link_active(link_active), .remote_rvalid(remote_rvalid),
      .remote_rstatus(remote_rstatus), .local_rvalid(local_rvalid),
      .local_rstatus(local_rstatus), .chip_link_error_int(chip_link_error_int));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_write <= w;
      avs_read <= ~w;
      avs_address <= a;
      avs_writedata <= d;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e,
      input logic [31:0] m);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task automatic t_dsp;
      rd(`BERH_OFS_ABORT_CTL, 32'h1, 32'h1);
      rd(6'h3C, 32'h0, 32'hFFFFFFFF);
      mc_u.answer(BERH_M_DSP, 1'b1, 1'b1, 32'h100, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk(resp_status, `BERH_ECC_RESP_STATUS);
      chk({resp_valid, resp_write, resp_master},
         {26'h0, 2'h3, BERH_M_DSP});
      chk(master_dma_port_err_int, 1'b1);
      rd(`BERH_OFS_DSP_CODE, 32'h4, 32'h7);
      rd(`BERH_OFS_DSP_PEND, 32'h3, 32'h3);
      bus(1'b1, `BERH_OFS_DSP_PEND, 32'h3);
      #1 chk(master_dma_port_err_int, 1'b0);
      mc_u.answer(BERH_M_DSP, 1'b0, 1'b1, 32'h104, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk(master_dma_port_err_int, 1'b1);
      // write error while pending is lost
      mc_u.answer(BERH_M_DSP, 1'b1, 1'b1, 32'h108, 4'h0, 2'h0,
         1'b0, 1'b0);
      rd(`BERH_OFS_DSP_PEND, 32'h1, 32'h3);
      $display("dsp test done");
   endtask
   task automatic t_app;
      mc_u.answer(BERH_M_APP, 1'b0, 1'b1, 32'h200, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk(app_ext_abort, 1'b0);
      bus(1'b1, `BERH_OFS_ABORT_CTL, 32'h0);
      mc_u.answer(BERH_M_APP, 1'b0, 1'b1, 32'h204, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk(app_ext_abort, 1'b1);
      mc_u.answer(BERH_M_APP, 1'b1, 1'b1, 32'h89AB, 4'h0, 2'h0, 1'b1, 1'b0);
      rd(`BERH_OFS_DATA_FAULT_ADDRESS_REG, 32'h89AB, 32'hFFFFFFFF);
      $display("app test done");
   endtask
   task automatic t_quiet;
      mc_u.answer(BERH_M_PCIE, 1'b0, 1'b1, 32'h300, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk(pcie_cpl_abort, 1'b1);
      mc_u.answer(BERH_M_PCIE, 1'b1, 1'b1, 32'h304, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk(pcie_cpl_abort, 1'b0);
      chk(dma_err_int, 1'b0);
      mc_u.answer(BERH_M_PKT_DMA, 1'b0, 1'b1, 32'h0, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk({dma_err_int, channel_error_event, rio_core_int}, 32'h0);
      mc_u.answer(BERH_M_ETH10G, 1'b0, 1'b1, 32'h0, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk(resp_status, `BERH_OK_STATUS);
      $display("quiet masters test done");
   endtask
   task automatic t_dma;
      mc_u.answer(BERH_M_DMA_TC, 1'b1, 1'b1, 32'h4450, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk(dma_xfer_done, 1'b1);
      chk(dma_err_int, 1'b0);
      rd(`BERH_OFS_TC_BUS_ERROR_CAPTURE_REG, 32'h1, 32'h1);
      rd(`BERH_OFS_TC_DETAIL, 32'h4450, 32'hFFFFFFFF);
      bus(1'b1, `BERH_OFS_TC_IEN, 32'h1);
      #1 chk(dma_err_int, 1'b1);
      $display("dma test done");
   endtask
   task automatic t_telecom_serial_port_rio;
      mc_u.answer(BERH_M_TELECOM_SERIAL_PORT, 1'b0, 1'b1, 32'h0, 4'h0, 2'h2, 1'b0, 1'b0);
      #1 chk(channel_error_event, 4'h4);
      mc_u.answer(BERH_M_TELECOM_SERIAL_PORT, 1'b1, 1'b1, 32'h0, 4'h0, 2'h0, 1'b0, 1'b0);
      #1 chk(channel_error_event, 4'h1);
      @(posedge clk);
      #1 chk(channel_error_event, 4'h0);
      bus(1'b1, `BERH_OFS_TELECOM_SERIAL_PORT_SEL, 32'h2);
      rd(`BERH_OFS_TELECOM_SERIAL_PORT_HEAD, 32'h9, 32'hF);
      bus(1'b1, `BERH_OFS_TELECOM_SERIAL_PORT_POP, 32'h0);
      rd(`BERH_OFS_TELECOM_SERIAL_PORT_HEAD, 32'h0, 32'h8);
      mc_u.answer(BERH_M_RIO, 1'b0, 1'b1, 32'h7700, 4'h3, 2'h0, 1'b0, 1'b0);
      rd(`BERH_OFS_RIO_STAT, 32'h8, 32'hFFFF);
      rd(`BERH_OFS_RIO_CAPT0, 32'h7700, 32'hFFFFFFFF);
      rd(`BERH_OFS_RIO_CAPT1, 32'h3A3, 32'hFFF);
      bus(1'b1, `BERH_OFS_RIO_ROUTE, 32'h80);
      @(posedge clk);
      #1 chk(rio_core_int, 4'h4);
      $display("telecom_serial_port and rio test done");
   endtask
   task automatic t_link;
      mc_u.answer(BERH_M_LINK, 1'b0, 1'b1, 32'h0, 4'h0, 2'h0, 1'b0, 1'b0);
      link_active <= 1'b1;
      remote_rvalid <= 1'b1;
      remote_rstatus <= 3'h5;
      @(posedge clk);
      remote_rvalid <= 1'b0;
      remote_rstatus <= 3'h2;
      #1 chk({local_rvalid, local_rstatus}, 4'hD);
      chk(chip_link_error_int, 1'b1);
      $display("link test done");
   endtask
   task automatic close_out;
      $display("compared %0d, wrong %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_dsp();
      t_app();
      t_quiet();
      t_dma();
      t_telecom_serial_port_rio();
      t_link();
      close_out();
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      errors++;
      close_out();
   end
endmodule
